/* File: asoi_capture.sv */
`timescale 1ns/10ps
// downstream capture logic watching the converter outputs
module asoi_capture import asoi_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// converter outputs
	input wire logic [ASOI_WIDTH-1:0] data_out,
	input wire logic output_strobe,
	input wire logic word_valid,
	// captured word, capture count and strobe period in clk cycles
	output logic [ASOI_WIDTH-1:0] cap_word,
	output logic [15:0] cap_count,
	output logic [11:0] strobe_period
);
	logic strobe_d;
	logic [11:0] per_cnt;
	wire logic strobe_rise;
	assign strobe_rise = output_strobe && !strobe_d;
	// latch on the strobe rise, midway between word updates, so the word has settled
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_d <= 1'b0;
			per_cnt <= 12'h000;
			cap_count <= 16'h0000;
			cap_word <= ASOI_WORD_ZERO;
			strobe_period <= 12'h000;
		end else begin
			strobe_d <= output_strobe;
			per_cnt <= strobe_rise ? 12'h001 : per_cnt + 12'h001;
			if (strobe_rise) strobe_period <= per_cnt;
			// words of a refilling pipeline are dropped until marked valid
			if (strobe_rise && word_valid) begin
				cap_word <= data_out;
				cap_count <= cap_count + 16'h0001;
			end
		end
	end
endmodule

/* File: asoi_pkg.sv */
package asoi_pkg;
	// ***************************************************
	// word format and pipeline geometry
	// ***************************************************
	localparam int ASOI_WIDTH = 12;
	localparam int ASOI_LATENCY = 7;
	localparam logic [2:0] ASOI_FILL_FULL = 3'h7;
	localparam logic [2:0] ASOI_FILL_ZERO = 3'h0;
	localparam logic [2:0] ASOI_FILL_STEP = 3'h1;
	localparam logic [11:0] ASOI_MSB_MASK = 12'h800;
	localparam logic [11:0] ASOI_WORD_ZERO = 12'h000;
	localparam logic [11:0] ASOI_CODE_BELOW_MID = 12'h7ff;
	localparam logic [11:0] ASOI_CODE_MID = 12'h800;
	// ***************************************************
	// select pin level codes (level 0 is the lowest voltage)
	// ***************************************************
	localparam int ASOI_SEL_W = 2;
	localparam int ASOI_CSEL_FMT_BIT = 0; // set: two's complement
	localparam int ASOI_CSEL_DIFF_BIT = 1; // set: differential clock
	localparam logic [1:0] ASOI_PWR_LVL_ON = 2'h0; // ground
	localparam logic [1:0] ASOI_PWR_LVL_SLEEP = 2'h1; // half supply
	localparam logic [1:0] ASOI_PWR_LVL_DOWN = 2'h2; // supply
	localparam logic [1:0] ASOI_PWR_LVL_DOWN2 = 2'h3; // above half counts as high
	typedef enum logic [1:0] {ASOI_PWR_ON, ASOI_PWR_SLEEP, ASOI_PWR_DOWN} asoi_pwr_t;
	// output coding from the raw offset binary code
	function automatic logic [11:0] asoi_code(input logic [11:0] raw, input logic twos);
		asoi_code = twos ? (raw ^ ASOI_MSB_MASK) : raw;
	endfunction
endpackage

/* File: asoi_sync.sv */
`timescale 1ns/10ps
// two flop synchroniser for levels from outside the clk domain
module asoi_sync import asoi_pkg::*; #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// level in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end
	assign q = q_reg;
endmodule

/* File: asoi_top.sv */
`timescale 1ns/10ps
// Contract
// - Each result is a 12-bit parallel word, with a strobe toggling at the clock rate.
// - A new sample is taken on every falling edge of the converter clock.
// - A sample's word is driven on the strobe fall seven clock cycles after it was taken.
// - Power-state pin high is power-down, half supply is sleep, ground is normal operation.
// - The output word changes only after a falling edge of the converter clock.
// - In offset binary the code passes from 2047 to 2048 where the input crosses zero.
// - Every output code can be reached; no code is ever absent.
// - Mid, negative and positive full scale map to the fixed codes of each coding.
// - In power-down or sleep the word is undefined and the pipeline contents are lost.
module asoi_top import asoi_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// converter clock and raw quantiser code (offset binary)
	input wire logic conv_clk,
	input wire logic [ASOI_WIDTH-1:0] raw_code,
	// select pins, as level codes
	input wire logic [ASOI_SEL_W-1:0] clock_and_format_select,
	input wire logic [ASOI_SEL_W-1:0] power_state_select,
	// output word and strobe
	output logic [ASOI_WIDTH-1:0] data_out,
	output logic output_strobe,
	output logic word_valid,
	// analog side controls
	output logic core_enable,
	output logic ref_buffer_enable,
	output logic clock_differential
);
	// ***************************************************
	// input synchronisers
	// ***************************************************
	logic ck_s;
	logic [ASOI_WIDTH-1:0] raw_s;
	logic [ASOI_SEL_W-1:0] csel_s;
	logic [ASOI_SEL_W-1:0] psel_s;
	asoi_sync #(.W(1)) u_ck (.clk(clk), .sys_rst(sys_rst), .d(conv_clk), .q(ck_s));
	// the code word is held steady around each converter fall and passes the same two
	// stages as that clock, so a detected fall never meets a word in motion
	asoi_sync #(.W(ASOI_WIDTH)) u_raw (.clk(clk), .sys_rst(sys_rst), .d(raw_code), .q(raw_s));
	asoi_sync #(.W(ASOI_SEL_W)) u_csel (.clk(clk), .sys_rst(sys_rst),
		.d(clock_and_format_select), .q(csel_s));
	asoi_sync #(.W(ASOI_SEL_W)) u_psel (.clk(clk), .sys_rst(sys_rst),
		.d(power_state_select), .q(psel_s));

	// ***************************************************
	// mode decode
	// ***************************************************
	logic ck_d_reg;
	logic ck_fall;
	logic twos;
	asoi_pwr_t pwr_reg;
	asoi_pwr_t pwr_next;
	logic run;
	// edge found on the second sync stage, never the first
	assign ck_fall = ck_d_reg & ~ck_s;
	assign twos = csel_s[ASOI_CSEL_FMT_BIT];
	assign clock_differential = csel_s[ASOI_CSEL_DIFF_BIT];
	assign run = (pwr_reg == ASOI_PWR_ON);

	// power state from the three-level pin
	always_comb begin
		case (psel_s)
			ASOI_PWR_LVL_ON: pwr_next = ASOI_PWR_ON;
			ASOI_PWR_LVL_SLEEP: pwr_next = ASOI_PWR_SLEEP;
			ASOI_PWR_LVL_DOWN: pwr_next = ASOI_PWR_DOWN;
			ASOI_PWR_LVL_DOWN2: pwr_next = ASOI_PWR_DOWN;
			default: pwr_next = ASOI_PWR_DOWN;
		endcase
	end
	// reference buffer stays up in sleep for the faster wake
	assign core_enable = run;
	assign ref_buffer_enable = (pwr_reg != ASOI_PWR_DOWN);

	// ***************************************************
	// seven stage pipeline
	// ***************************************************
	logic [ASOI_WIDTH-1:0] pipe_reg [ASOI_LATENCY];
	logic [ASOI_WIDTH-1:0] data_reg;
	logic strobe_reg;
	logic valid_reg;
	logic [2:0] fill_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ck_d_reg <= 1'b0;
			pwr_reg <= ASOI_PWR_DOWN;
		end else begin
			ck_d_reg <= ck_s;
			pwr_reg <= pwr_next;
		end
	end

	// one sample per converter fall; sleep or power-down flushes everything
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < ASOI_LATENCY; i++) pipe_reg[i] <= ASOI_WORD_ZERO;
		end else if (!run) begin
			for (int i = 0; i < ASOI_LATENCY; i++) pipe_reg[i] <= ASOI_WORD_ZERO;
		end else if (ck_fall) begin
			pipe_reg[0] <= raw_s;
			for (int i = 1; i < ASOI_LATENCY; i++) pipe_reg[i] <= pipe_reg[i-1];
		end
	end

	// word and strobe move together, so the word changes on the strobe fall
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_reg <= ASOI_WORD_ZERO;
			strobe_reg <= 1'b0;
		end else if (!run) begin
			data_reg <= ASOI_WORD_ZERO;
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= ck_s;
			if (ck_fall) begin
				data_reg <= asoi_code(pipe_reg[ASOI_LATENCY-1], twos);
			end
		end
	end

	// valid only once a full pipeline of fresh samples has emerged
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fill_reg <= ASOI_FILL_ZERO;
			valid_reg <= 1'b0;
		end else if (!run) begin
			fill_reg <= ASOI_FILL_ZERO;
			valid_reg <= 1'b0;
		end else if (ck_fall) begin
			if (fill_reg != ASOI_FILL_FULL) fill_reg <= fill_reg + ASOI_FILL_STEP;
			valid_reg <= (fill_reg == ASOI_FILL_FULL);
		end
	end

	assign data_out = data_reg;
	assign output_strobe = strobe_reg;
	assign word_valid = valid_reg;

	// ***************************************************
	// recovery tracking for the checks below
	// ***************************************************
	// falls seen since the last return to normal, saturating just past the pipeline depth
	int wake_falls_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_falls_reg <= '0;
		end else if (!run) begin
			wake_falls_reg <= '0;
		end else if (ck_fall && wake_falls_reg <= ASOI_LATENCY) begin
			wake_falls_reg <= wake_falls_reg + ASOI_FILL_STEP;
		end
	end

	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// pipeline entry, latency and output coding
	stage_in_a: assert property (run && ck_fall |=> pipe_reg[0] == $past(raw_s))
		else $error("sample not taken on converter fall");
	word_lat_a: assert property (run && $past(run) && ck_fall |=>
		data_out[ASOI_WIDTH-2:0] == $past(pipe_reg[ASOI_LATENCY-1][ASOI_WIDTH-2:0])
		&& data_out[ASOI_WIDTH-1] ==
		($past(pipe_reg[ASOI_LATENCY-1][ASOI_WIDTH-1]) ^ $past(twos)))
		else $error("output word does not match pipeline tail");
	mid_code_a: assert property (run && ck_fall &&
		pipe_reg[ASOI_LATENCY-1] == ASOI_CODE_MID |=>
		data_out == ($past(twos) ? ASOI_WORD_ZERO : ASOI_CODE_MID))
		else $error("mid-scale code wrong on output");
	below_mid_a: assert property (run && ck_fall &&
		pipe_reg[ASOI_LATENCY-1] == ASOI_CODE_BELOW_MID |=>
		data_out == ($past(twos) ? (ASOI_CODE_BELOW_MID | ASOI_MSB_MASK)
		: ASOI_CODE_BELOW_MID))
		else $error("code below mid scale wrong on output");
	word_hold_a: assert property (run && $past(run) && !ck_fall |=> $stable(data_out))
		else $error("output word changed without converter fall");

	// strobe timing
	strobe_fall_a: assert property (run && $past(run) && $fell(output_strobe) |->
		$past(ck_fall))
		else $error("strobe fall not tied to converter fall");
	strobe_rate_a: assert property (run && ck_fall |=> !output_strobe)
		else $error("strobe not low after converter fall");
	strobe_copy_a: assert property (run && $past(run) |-> output_strobe == $past(ck_s))
		else $error("strobe does not follow converter clock");
	strobe_rise_a: assert property (run && $past(run) && $rose(output_strobe) |->
		$stable(data_out))
		else $error("output word moved at strobe rise");

	// power states
	sleep_flush_a: assert property (!run |=> data_out == ASOI_WORD_ZERO && !word_valid
		&& pipe_reg[0] == ASOI_WORD_ZERO)
		else $error("pipeline not flushed while powered down");
	strobe_idle_a: assert property (!run |=> !output_strobe)
		else $error("strobe running while powered down");
	on_map_a: assert property (psel_s == ASOI_PWR_LVL_ON |=> core_enable
		&& ref_buffer_enable)
		else $error("normal level decoded wrong");
	pwr_map_a: assert property (psel_s == ASOI_PWR_LVL_SLEEP |=> !core_enable
		&& ref_buffer_enable)
		else $error("sleep level decoded wrong");
	down_map_a: assert property (psel_s == ASOI_PWR_LVL_DOWN |=> !core_enable
		&& !ref_buffer_enable)
		else $error("power-down level decoded wrong");
	down2_map_a: assert property (psel_s == ASOI_PWR_LVL_DOWN2 |=> !core_enable
		&& !ref_buffer_enable)
		else $error("top level not decoded as power-down");

	// recovery after sleep or power-down
	valid_gap_a: assert property ($rose(run) |-> !word_valid [*8])
		else $error("word marked valid right after recovery");
	valid_on_a: assert property (run && ck_fall && fill_reg == ASOI_FILL_FULL |=> word_valid)
		else $error("word not marked valid after refill");
	valid_wait_a: assert property (word_valid |-> wake_falls_reg > ASOI_LATENCY)
		else $error("word marked valid before pipeline refilled");

	// main scenarios, each seen at least once
	run_cov_c: cover property (run && ck_fall ##1 word_valid);
	twos_cov_c: cover property (twos && word_valid && data_out == ASOI_WORD_ZERO);
	mid_cov_c: cover property (!twos && word_valid && data_out == ASOI_CODE_MID);
	sleep_cov_c: cover property (pwr_reg == ASOI_PWR_SLEEP ##1 run);
	down_cov_c: cover property (pwr_reg == ASOI_PWR_DOWN ##1 run);
endmodule

/* File: test_adc_sample_output_interface.sv */
`timescale 1ns/10ps
module test_adc_sample_output_interface import asoi_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic conv_clk = 1'b0;
	logic sweep = 1'b0;
	logic [11:0] raw_code = 12'h000;
	logic [1:0] clock_and_format_select = 2'h0;
	logic [1:0] power_state_select = 2'h0;
	logic [11:0] data_out, cap_word, strobe_period;
	logic [15:0] cap_count;
	logic output_strobe, word_valid, core_enable, ref_buffer_enable, clock_differential;
	logic [11:0] hist [16];
	logic [11:0] codes [8] = '{12'h000, 12'h7ff, 12'h800, 12'hfff,
		12'h400, 12'hc00, 12'h001, 12'hffe};
	int errors = 0, n_tests = 0, cyc = 0, nfall = 0, cdiv = 0;
	asoi_top u_dut (.clk, .sys_rst, .conv_clk, .raw_code, .clock_and_format_select,
		.power_state_select, .data_out, .output_strobe, .word_valid, .core_enable,
		.ref_buffer_enable, .clock_differential);
	asoi_capture u_cap (.clk, .sys_rst, .data_out, .output_strobe, .word_valid, .cap_word,
		.cap_count, .strobe_period);
	always #12.5 clk = ~clk;
	// 5 MHz converter clock, sample source and hang limit, all just after the clk edge
	always @(posedge clk) begin
		#1;
		cyc++;
		if (cdiv == 3) begin
			conv_clk = ~conv_clk;
			if (conv_clk) raw_code = sweep ? nfall[11:0] : codes[nfall % 8];
			else begin
				hist[nfall % 16] = raw_code;
				nfall++;
			end
		end
		cdiv = (cdiv + 1) % 4;
		// hang limit last, so nothing in this pass follows the verdict
		if (cyc == 60000) begin
			errors++;
			results;
		end
	end
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// each captured word must be the sample taken seven converter falls earlier
	task automatic run_stream(input logic [1:0] sel, input int n);
		logic [15:0] seen;
		logic [11:0] h;
		int t;
		@(posedge clk);
		#1 clock_and_format_select = sel;
		repeat (8) @(posedge clk);
		#2 check("clock_diff", {11'h0, clock_differential}, {11'h0, sel[1]});
		seen = cap_count;
		for (int k = 0; k < n; k++) begin
			t = 0;
			while (cap_count === seen && t < 40) begin
				@(posedge clk);
				#2 t++;
			end
			check("strobe_seen", {11'h0, cap_count !== seen}, 12'h001);
			seen = cap_count;
			// a converter fall may land just before this look, shifting the index by one
			h = hist[(nfall - (conv_clk ? 8 : 9)) % 16];
			check("word", cap_word, sel[0] ? h ^ ASOI_MSB_MASK : h);
			check("period", strobe_period, 12'h008);
		end
	endtask
	// sleep and power-down stop the stream; words after wake come from fresh samples only
	task automatic run_power(input logic [1:0] lvl);
		int t;
		int f0;
		@(posedge clk);
		#1 power_state_select = lvl;
		repeat (24) @(posedge clk);
		#2 check("core_enable", {11'h0, core_enable}, 12'h000);
		check("ref_buffer", {11'h0, ref_buffer_enable},
			{11'h0, lvl == ASOI_PWR_LVL_SLEEP});
		check("stopped", data_out | {10'h0, output_strobe, word_valid}, 12'h000);
		@(posedge clk);
		#1 power_state_select = ASOI_PWR_LVL_ON;
		f0 = nfall;
		t = 0;
		while (word_valid !== 1'b1 && t < 200) begin
			@(posedge clk);
			#2 t++;
		end
		check("discarded", {11'h0, nfall - f0 >= 7}, 12'h001);
		check("valid_back", {11'h0, word_valid}, 12'h001);
		check("core_back", {11'h0, core_enable & ref_buffer_enable}, 12'h001);
		run_stream(2'h0, 4);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 sys_rst = 1'b0;
		// let the pipeline fill with well over seven samples after reset
		repeat (120) @(posedge clk);
		for (int s = 0; s < 4; s++) run_stream(s[1:0], 12);
		sweep = 1'b1;
		run_stream(2'h0, 4100);
		sweep = 1'b0;
		run_power(ASOI_PWR_LVL_SLEEP);
		run_power(ASOI_PWR_LVL_DOWN);
		run_power(ASOI_PWR_LVL_DOWN2);
		results;
	end
endmodule
